/* File: pmx_media_regs.sv */
/*
 * media mode and line tuning control registers behind the management register port.
 * assumes a synchronous 5-bit address, write strobe, and a software reset pulse from control register 0.
 */
`default_nettype none
`include "pmx_map.svh"
module pmx_media_regs (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [4:0] reg_addr,
	input wire logic reg_wr,
	input wire pmx_pkg::pmx_word_t reg_wdata,
	input wire logic sw_reset,
	input wire logic sticky_reset_en,
	input wire logic [1:0] global_serdes_sel,
	output pmx_pkg::pmx_word_t reg_rdata,
	output logic iface_1000x,
	output logic iface_valid,
	output logic copper_preferred,
	output pmx_pkg::pmx_media_e media_mode,
	output logic ams_enabled,
	output pmx_pkg::pmx_ovr_e ams_override,
	output logic far_end_loopback,
	output logic [2:0] edge_rate,
	output logic reduced_power,
	output logic [1:0] jumbo_mode,
	output logic connector_loopback,
	output logic reserved_code
);
	import pmx_pkg::*;
	pmx_cfg_if cfg ();
	logic apply;
	logic clear_sticky;

	// ==========================================
	// sub-blocks
	pmx_sw_reset u_swr (
		.clock(clock),
		.rst_b(rst_b),
		.sw_reset(sw_reset),
		.sticky_en(sticky_reset_en),
		.apply(apply),
		.clear_sticky(clear_sticky)
	);
	pmx_mode_hold u_hold (
		.clock(clock),
		.rst_b(rst_b),
		.cfg(cfg)
	);

	// ==========================================
	// register state
	pmx_mode_s pend_reg, pend_next;
	logic [2:0] rsv_reg, rsv_next;
	pmx_ovr_e ovr_reg, ovr_next;
	logic felb_reg, felb_next;
	logic [2:0] edge_reg, edge_next;
	logic lpwr_reg, lpwr_next;
	logic [1:0] jumbo_reg, jumbo_next;
	logic clb_reg, clb_next;
	pmx_word_t rdata_reg, rdata_next;
	logic [6:0] out_reg, out_next;
	logic rsvd_reg, rsvd_next;
	logic wr_media;
	logic wr_tune;
	pmx_mode_s act;

	assign wr_media = reg_wr && (reg_addr == `PMX_MEDIA_OFS);
	assign wr_tune = reg_wr && (reg_addr == `PMX_TUNE_OFS);
	assign cfg.pending = pend_reg;
	assign cfg.apply = apply;
	assign act = cfg.active;

	always_comb begin
		pend_next = pend_reg;
		rsv_next = rsv_reg;
		ovr_next = ovr_reg;
		felb_next = felb_reg;
		edge_next = edge_reg;
		lpwr_next = lpwr_reg;
		jumbo_next = jumbo_reg;
		clb_next = clb_reg;
		// sticky fields fall back first, so a write in the same cycle still lands
		if (clear_sticky) begin
			edge_next = `PMX_EDGE_RST;
			lpwr_next = 1'b0;
			jumbo_next = `PMX_JUMBO_RST;
		end
		if (wr_media) begin
			// mode fields to the pending copy; rsv, override and far-end loopback land directly; super-sticky fields are never touched by software reset
			pend_next.iface_1000x = reg_wdata[`PMX_IFACE_BIT];
			pend_next.copper_pref = reg_wdata[`PMX_PREF_BIT];
			pend_next.mode = pmx_media_e'(reg_wdata[`PMX_MODE_HI:`PMX_MODE_LO]);
			rsv_next = reg_wdata[`PMX_RSV_HI:`PMX_RSV_LO];
			ovr_next = pmx_ovr_e'(reg_wdata[`PMX_OVR_HI:`PMX_OVR_LO]);
			felb_next = reg_wdata[`PMX_FELB_BIT];
		end
		if (wr_tune) begin
			edge_next = reg_wdata[`PMX_EDGE_HI:`PMX_EDGE_LO];
			lpwr_next = reg_wdata[`PMX_LPWR_BIT];
			jumbo_next = reg_wdata[`PMX_JUMBO_HI:`PMX_JUMBO_LO];
			clb_next = reg_wdata[`PMX_CLB_BIT];
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pend_reg <= '{1'b0, 1'b0, PMX_COPPER_ONLY};
			rsv_reg <= `PMX_RSV_RST;
			ovr_reg <= PMX_OVR_NORMAL;
			felb_reg <= 1'b0;
			edge_reg <= `PMX_EDGE_RST;
			lpwr_reg <= 1'b0;
			jumbo_reg <= `PMX_JUMBO_RST;
			clb_reg <= 1'b0;
		end else begin
			pend_reg <= pend_next;
			rsv_reg <= rsv_next;
			ovr_reg <= ovr_next;
			felb_reg <= felb_next;
			edge_reg <= edge_next;
			lpwr_reg <= lpwr_next;
			jumbo_reg <= jumbo_next;
			clb_reg <= clb_next;
		end
	end

	// ==========================================
	// read path: registered, one cycle after the address
	always_comb begin
		rdata_next = '0;
		case (reg_addr)
			`PMX_MEDIA_OFS: begin
				rdata_next[`PMX_RSV_HI:`PMX_RSV_LO] = rsv_reg;
				rdata_next[`PMX_IFACE_BIT] = act.iface_1000x;
				rdata_next[`PMX_PREF_BIT] = act.copper_pref;
				rdata_next[`PMX_MODE_HI:`PMX_MODE_LO] = act.mode;
				rdata_next[`PMX_OVR_HI:`PMX_OVR_LO] = ovr_reg;
				rdata_next[`PMX_FELB_BIT] = felb_reg;
			end
			`PMX_TUNE_OFS: begin
				rdata_next[`PMX_EDGE_HI:`PMX_EDGE_LO] = edge_reg;
				rdata_next[`PMX_LPWR_BIT] = lpwr_reg;
				rdata_next[`PMX_JUMBO_HI:`PMX_JUMBO_LO] = jumbo_reg;
				rdata_next[`PMX_CLB_BIT] = clb_reg;
			end
			default: begin
				rdata_next = '0;
			end
		endcase
	end

	// ==========================================
	// control outputs, all from flip-flops
	always_comb begin
		out_next = '0;
		out_next[0] = act.iface_1000x;
		out_next[1] = (global_serdes_sel == `PMX_GSEL_OK);
		out_next[2] = act.copper_pref;
		out_next[3] = (act.mode >= `PMX_AMS_MIN);
		out_next[4] = felb_reg;
		out_next[5] = clb_reg;
		out_next[6] = lpwr_reg;
		// flags reserved codes in effect; software is expected to avoid them
		rsvd_next = (act.mode == `PMX_MODE_RSVD) || (ovr_reg == `PMX_OVR_RSVD)
			|| (jumbo_reg == `PMX_JUMBO_RSVD);
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rdata_reg <= '0;
			out_reg <= '0;
			rsvd_reg <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			out_reg <= out_next;
			rsvd_reg <= rsvd_next;
		end
	end

	pmx_media_e mode_q;
	pmx_ovr_e ovr_q;
	logic [2:0] edge_q;
	logic [1:0] jumbo_q;
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			mode_q <= PMX_COPPER_ONLY;
			ovr_q <= PMX_OVR_NORMAL;
			edge_q <= `PMX_EDGE_RST;
			jumbo_q <= `PMX_JUMBO_RST;
		end else begin
			mode_q <= act.mode;
			ovr_q <= ovr_reg;
			edge_q <= edge_reg;
			jumbo_q <= jumbo_reg;
		end
	end

	assign reg_rdata = rdata_reg;
	assign iface_1000x = out_reg[0];
	assign iface_valid = out_reg[1];
	assign copper_preferred = out_reg[2];
	assign ams_enabled = out_reg[3];
	assign far_end_loopback = out_reg[4];
	assign connector_loopback = out_reg[5];
	assign reduced_power = out_reg[6];
	assign media_mode = mode_q;
	assign ams_override = ovr_q;
	assign edge_rate = edge_q;
	assign jumbo_mode = jumbo_q;
	assign reserved_code = rsvd_reg;

	// ==========================================
	// checks: pending and active mode copies
	// the read may only follow a write once the apply pulse has been through the holder
	chk_pending_not_read: assert property (@(posedge clock) disable iff (!rst_b)
		wr_media && !apply && !sw_reset ##1 !apply && reg_addr == `PMX_MEDIA_OFS
		|=> reg_rdata[`PMX_MODE_HI:`PMX_MODE_LO] == $past(act.mode))
		else $error("read shows pending mode");
	chk_read_active_mode: assert property (@(posedge clock) disable iff (!rst_b)
		reg_addr == `PMX_MEDIA_OFS |=> reg_rdata[`PMX_IFACE_BIT:`PMX_MODE_LO] == $past(act))
		else $error("mode bits read not the active copy");
	chk_pending_write: assert property (@(posedge clock) disable iff (!rst_b)
		wr_media |=> pend_reg == $past(reg_wdata[`PMX_IFACE_BIT:`PMX_MODE_LO]))
		else $error("pending copy not written");
	chk_mode_after_reset: assert property (@(posedge clock) disable iff (!rst_b)
		sw_reset |-> ##3 media_mode == $past(pend_reg.mode, 2))
		else $error("mode not in effect");
	chk_super_sticky_kept: assert property (@(posedge clock) disable iff (!rst_b)
		clear_sticky && !wr_media |=> $stable(pend_reg))
		else $error("super-sticky field lost at software reset");

	// ==========================================
	// checks: sticky fields across software reset
	chk_sticky_kept: assert property (@(posedge clock) disable iff (!rst_b)
		sw_reset && sticky_reset_en && !wr_tune ##1 !wr_tune |=> edge_reg == $past(edge_reg, 2)
		&& jumbo_reg == $past(jumbo_reg, 2) && lpwr_reg == $past(lpwr_reg, 2))
		else $error("sticky field lost");
	chk_sticky_cleared: assert property (@(posedge clock) disable iff (!rst_b)
		sw_reset && !sticky_reset_en ##1 !wr_tune |=> edge_reg == `PMX_EDGE_RST
		&& jumbo_reg == `PMX_JUMBO_RST && !lpwr_reg)
		else $error("sticky field not cleared");

	// ==========================================
	// checks: field writes, reads and control outputs
	// outputs trail the state by one flop, so each is held against the state a cycle back
	chk_edge_write: assert property (@(posedge clock) disable iff (!rst_b)
		wr_tune |=> ##1 edge_rate == $past(reg_wdata[`PMX_EDGE_HI:`PMX_EDGE_LO], 2))
		else $error("edge rate lost");
	chk_edge_read: assert property (@(posedge clock) disable iff (!rst_b)
		reg_addr == `PMX_TUNE_OFS |=> reg_rdata[`PMX_EDGE_HI:`PMX_EDGE_LO] == $past(edge_reg))
		else $error("edge rate read wrong");
	chk_lpwr_write: assert property (@(posedge clock) disable iff (!rst_b)
		wr_tune |=> lpwr_reg == $past(reg_wdata[`PMX_LPWR_BIT]))
		else $error("low power lost");
	chk_lpwr_read: assert property (@(posedge clock) disable iff (!rst_b)
		reg_addr == `PMX_TUNE_OFS |=> reg_rdata[`PMX_LPWR_BIT] == $past(lpwr_reg))
		else $error("low power read wrong");
	chk_jumbo_write: assert property (@(posedge clock) disable iff (!rst_b)
		wr_tune |=> jumbo_reg == $past(reg_wdata[`PMX_JUMBO_HI:`PMX_JUMBO_LO]))
		else $error("jumbo lost");
	chk_jumbo_read: assert property (@(posedge clock) disable iff (!rst_b)
		reg_addr == `PMX_TUNE_OFS |=> reg_rdata[`PMX_JUMBO_HI:`PMX_JUMBO_LO] == $past(jumbo_reg))
		else $error("jumbo read wrong");
	chk_ovr_out: assert property (@(posedge clock) disable iff (!rst_b)
		wr_media |=> ##1 ams_override == $past(reg_wdata[`PMX_OVR_HI:`PMX_OVR_LO], 2))
		else $error("override lost");
	chk_ams_flag: assert property (@(posedge clock) disable iff (!rst_b)
		##1 ams_enabled == ($past(act.mode) >= `PMX_AMS_MIN))
		else $error("ams flag wrong");
	chk_mode_out: assert property (@(posedge clock) disable iff (!rst_b)
		##1 media_mode == $past(act.mode))
		else $error("mode output wrong");
	chk_iface_valid: assert property (@(posedge clock) disable iff (!rst_b)
		$past(rst_b) |-> iface_valid == ($past(global_serdes_sel) == `PMX_GSEL_OK))
		else $error("valid flag wrong");
	chk_iface_out: assert property (@(posedge clock) disable iff (!rst_b)
		##1 iface_1000x == $past(act.iface_1000x))
		else $error("interface output wrong");
	chk_pref_out: assert property (@(posedge clock) disable iff (!rst_b)
		##1 copper_preferred == $past(act.copper_pref))
		else $error("preference output wrong");
	chk_rsvd_flag: assert property (@(posedge clock) disable iff (!rst_b)
		##1 reserved_code == ($past(act.mode) == `PMX_MODE_RSVD || $past(ovr_reg) == `PMX_OVR_RSVD
		|| $past(jumbo_reg) == `PMX_JUMBO_RSVD))
		else $error("reserved code flag wrong");

	// ==========================================
	// scenarios worth seeing
	cov_mode_apply: cover property (@(posedge clock) disable iff (!rst_b) wr_media ##[1:4] sw_reset);
	cov_sticky_clear: cover property (@(posedge clock) disable iff (!rst_b) sw_reset && !sticky_reset_en);
	cov_sticky_keep: cover property (@(posedge clock) disable iff (!rst_b) sw_reset && sticky_reset_en);
	cov_ams_applied: cover property (@(posedge clock) disable iff (!rst_b) apply && pend_reg.mode >= `PMX_AMS_MIN);
	cov_jumbo_12k: cover property (@(posedge clock) disable iff (!rst_b) jumbo_mode == 2'h2);
endmodule
`default_nettype wire

/* File: pmx_map.svh */
/*
 * offsets, field positions, reset values and codes of the media and line tuning control registers.
 * assumes inclusion by bare name from the design files.
 */
`ifndef PMX_MAP_SVH
`define PMX_MAP_SVH
// ==========================================
// register offsets
`define PMX_MEDIA_OFS 5'h17
`define PMX_TUNE_OFS 5'h18
// ==========================================
// media register fields
`define PMX_IFACE_BIT 12
`define PMX_PREF_BIT 11
`define PMX_MODE_HI 10
`define PMX_MODE_LO 8
`define PMX_OVR_HI 7
`define PMX_OVR_LO 6
`define PMX_FELB_BIT 3
`define PMX_RSV_HI 15
`define PMX_RSV_LO 13
// ==========================================
// tuning register fields
`define PMX_EDGE_HI 15
`define PMX_EDGE_LO 13
`define PMX_LPWR_BIT 12
`define PMX_JUMBO_HI 5
`define PMX_JUMBO_LO 4
`define PMX_CLB_BIT 0
// ==========================================
// reset values and codes
`define PMX_EDGE_RST 3'h0
`define PMX_MODE_RST 3'h0
`define PMX_OVR_RST 2'h0
`define PMX_JUMBO_RST 2'h0
`define PMX_RSV_RST 3'h0
`define PMX_MODE_RSVD 3'h4
`define PMX_OVR_RSVD 2'h3
`define PMX_JUMBO_RSVD 2'h3
`define PMX_AMS_MIN 3'h5
`define PMX_GSEL_OK 2'h0
`define PMX_PPM_DEFAULT 100
`endif

/* File: pmx_pkg.sv */
/*
 * types shared by the media and line tuning control registers.
 * assumes the map header for numeric values.
 */
`default_nettype none
package pmx_pkg;
	typedef enum logic [2:0] {
		PMX_COPPER_ONLY = 3'h0,
		PMX_SERDES_ONLY = 3'h1,
		PMX_FIBER_X_ONLY = 3'h2,
		PMX_FIBER_FX_ONLY = 3'h3,
		PMX_MODE_RESERVED = 3'h4,
		PMX_AMS_SERDES = 3'h5,
		PMX_AMS_FIBER_X = 3'h6,
		PMX_AMS_FIBER_FX = 3'h7
	} pmx_media_e;
	typedef enum logic [1:0] {
		PMX_OVR_NORMAL = 2'h0,
		PMX_OVR_SERDES = 2'h1,
		PMX_OVR_COPPER = 2'h2,
		PMX_OVR_RESERVED = 2'h3
	} pmx_ovr_e;
	typedef struct packed {
		logic iface_1000x;
		logic copper_pref;
		pmx_media_e mode;
	} pmx_mode_s;
	typedef logic [15:0] pmx_word_t;
endpackage
`default_nettype wire

/* File: pmx_cfg_if.sv */
/*
 * carrier between the register bank top and its mode holder.
 * assumes one clock domain.
 */
`default_nettype none
interface pmx_cfg_if;
	import pmx_pkg::*;
	pmx_mode_s pending;
	logic apply;
	pmx_mode_s active;
	modport bank (output pending, output apply, input active);
	modport holder (input pending, input apply, output active);
endinterface
`default_nettype wire

/* File: pmx_mode_hold.sv */
/*
 * active copy of the super-sticky mode fields, loaded from the pending copy at software reset.
 * assumes apply is a one-cycle pulse from the register bank.
 */
`default_nettype none
`include "pmx_map.svh"
module pmx_mode_hold (
	input wire logic clock,
	input wire logic rst_b,
	pmx_cfg_if.holder cfg
);
	import pmx_pkg::*;
	pmx_mode_s active_reg;
	pmx_mode_s active_next;
	always_comb begin
		active_next = active_reg;
		if (cfg.apply) begin
			active_next = cfg.pending;
		end
	end
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			active_reg <= '{1'b0, 1'b0, PMX_COPPER_ONLY};
		end else begin
			active_reg <= active_next;
		end
	end
	assign cfg.active = active_reg;
	chk_apply_loads_mode: assert property (@(posedge clock) disable iff (!rst_b)
		cfg.apply |=> active_reg == $past(cfg.pending)) else $error("mode not applied");
	chk_mode_holds_idle: assert property (@(posedge clock) disable iff (!rst_b)
		!cfg.apply |=> $stable(active_reg)) else $error("mode changed without reset");
endmodule
`default_nettype wire

/* File: pmx_sw_reset.sv */
/*
 * sticky field reset control: decides restore-to-default on software reset.
 * assumes sw_reset is a one-cycle pulse.
 */
`default_nettype none
`include "pmx_map.svh"
module pmx_sw_reset (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic sw_reset,
	input wire logic sticky_en,
	output logic apply,
	output logic clear_sticky
);
	logic apply_reg;
	logic apply_next;
	logic clr_reg;
	logic clr_next;
	always_comb begin
		apply_next = sw_reset;
		clr_next = sw_reset && !sticky_en;
	end
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			apply_reg <= 1'b0;
			clr_reg <= 1'b0;
		end else begin
			apply_reg <= apply_next;
			clr_reg <= clr_next;
		end
	end
	assign apply = apply_reg;
	assign clear_sticky = clr_reg;
	chk_clear_needs_reset: assert property (@(posedge clock) disable iff (!rst_b)
		clr_reg |-> apply_reg) else $error("sticky clear without reset");
endmodule
`default_nettype wire

/* File: pmx_media_regs_test.sv */
/*
 * self-checking bench for the media mode and line tuning control registers, with an integer model.
 * assumes the map header, package, interface and design modules are compiled before this file.
 */
`default_nettype none
module pmx_media_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	import pmx_pkg::*;
	logic clock, rst_b, reg_wr, sw_reset, sticky_reset_en;
	logic [4:0] reg_addr;
	pmx_word_t reg_wdata, reg_rdata;
	logic [1:0] global_serdes_sel, jumbo_mode;
	logic iface_1000x, iface_valid, copper_preferred, ams_enabled, far_end_loopback;
	logic reduced_power, connector_loopback, reserved_code;
	logic [2:0] edge_rate;
	pmx_media_e media_mode;
	pmx_ovr_e ams_override;
	int fails = 0;
	int n_checks = 0;
	int cycles = 0;
	// model: pending and active mode copies are kept apart, as the device does
	int m_rsv, m_act, m_ovr, m_felb, m_edge, m_lpwr, m_jumbo, m_clb;
	int m_pend_q[$];
	int i;

	pmx_media_regs u_dut (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .sw_reset(sw_reset), .sticky_reset_en(sticky_reset_en),
		.global_serdes_sel(global_serdes_sel), .reg_rdata(reg_rdata), .iface_1000x(iface_1000x),
		.iface_valid(iface_valid), .copper_preferred(copper_preferred), .media_mode(media_mode),
		.ams_enabled(ams_enabled), .ams_override(ams_override), .far_end_loopback(far_end_loopback),
		.edge_rate(edge_rate), .reduced_power(reduced_power), .jumbo_mode(jumbo_mode),
		.connector_loopback(connector_loopback), .reserved_code(reserved_code));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// ==========================================
	// reporting
	task final_report;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	always @(posedge clock) begin
		cycles++;
		if (cycles > 20000) begin
			fails++;
			final_report();
		end
	end

	task cmp(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
			fails++;
		end
	endtask

	// ==========================================
	// bus tasks
	// bit 13 of the media register is kept at 0: it sits inside both the gated and the stored range
	task wr(input int a, input int v);
		int dv;
		dv = (a == 'h17) ? (v & 'hdfff) : v;
		@(posedge clock);
		reg_addr <= 5'(a);
		reg_wr <= 1'b1;
		reg_wdata <= 16'(dv);
		if (a == 'h17) begin
			m_rsv = (dv >> 13) & 7;
			m_pend_q.push_back((dv >> 8) & 31);
			m_ovr = (dv >> 6) & 3;
			m_felb = (dv >> 3) & 1;
		end
		if (a == 'h18) begin
			m_edge = (dv >> 13) & 7;
			m_lpwr = (dv >> 12) & 1;
			m_jumbo = (dv >> 4) & 3;
			m_clb = dv & 1;
		end
	endtask

	task idle;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	task swr(input int keep);
		@(posedge clock);
		sticky_reset_en <= keep[0];
		@(posedge clock);
		sw_reset <= 1'b1;
		@(posedge clock);
		sw_reset <= 1'b0;
		// only the newest pending write reaches the active copy
		if (m_pend_q.size() > 0) begin
			m_act = m_pend_q[$];
		end
		m_pend_q.delete();
		if (keep == 0) begin
			m_edge = 0;
			m_lpwr = 0;
			m_jumbo = 0;
		end
	endtask

	task rdchk(input string nm, input int a, input int e);
		@(posedge clock);
		reg_addr <= 5'(a);
		repeat (2) @(posedge clock);
		#1 cmp(nm, 16'(e), reg_rdata);
	endtask

	task chk;
		int md;
		md = m_act & 7;
		repeat (4) @(posedge clock);
		#1;
		cmp("iface", 16'((m_act >> 4) & 1), 16'(iface_1000x));
		cmp("valid", 16'(global_serdes_sel == 2'h0), 16'(iface_valid));
		cmp("pref", 16'((m_act >> 3) & 1), 16'(copper_preferred));
		cmp("mode", 16'(md), 16'(media_mode));
		cmp("ams", 16'(md >= 5), 16'(ams_enabled));
		cmp("ovr", 16'(m_ovr), 16'(ams_override));
		cmp("rsvd", 16'(md == 4 || m_ovr == 3 || m_jumbo == 3), 16'(reserved_code));
		cmp("tune", 16'(m_edge << 5 | m_lpwr << 4 | m_jumbo << 2 | m_clb << 1 | m_felb),
			16'({edge_rate, reduced_power, jumbo_mode, connector_loopback, far_end_loopback}));
		rdchk("rd_media", 'h17, m_rsv << 13 | m_act << 8 | m_ovr << 6 | m_felb << 3);
		rdchk("rd_tune", 'h18, m_edge << 13 | m_lpwr << 12 | m_jumbo << 4 | m_clb);
		rdchk("rd_none", $urandom_range(31, 25), 0);
	endtask

	// ==========================================
	// main sequence
	initial begin
		rst_b = 1'b0;
		reg_wr = 1'b0;
		sw_reset = 1'b0;
		sticky_reset_en = 1'b0;
		reg_addr = 5'h00;
		reg_wdata = 16'h0000;
		global_serdes_sel = 2'h0;
		{m_rsv, m_act, m_ovr, m_felb, m_edge, m_lpwr, m_jumbo, m_clb} = '0;
		repeat (16) @(posedge clock);
		rst_b <= 1'b1;
		void'($urandom(84));
		chk();
		// every mode, override, edge and jumbo code, with pending values checked before they apply
		for (i = 0; i < 8; i++) begin
			wr('h17, i << 8 | (i & 1) << 12 | (i & 2) << 10 | (i & 3) << 6 | (i & 4) << 1);
			idle();
			global_serdes_sel <= 2'(i);
			chk();
			swr(i & 1);
			chk();
			// reference offset is the system's concern; edge rate, low power, length code and connector loopback are set here
			wr('h18, i << 13 | (i & 1) << 12 | (i & 3) << 4 | (i >> 2));
			idle();
			chk();
		end
		swr(1);
		chk();
		swr(0);
		chk();
		// random back-to-back writes, unmapped addresses and read-only bits included
		for (i = 0; i < 40; i++) begin
			wr($urandom_range('h18, 'h16), $urandom());
			wr($urandom_range('h19, 'h17), $urandom());
			idle();
			global_serdes_sel <= 2'($urandom());
			if ($urandom_range(1, 0) == 1) begin
				swr($urandom_range(1, 0));
			end
			chk();
		end
		final_report();
	end
endmodule
`default_nettype wire
